/* logic/dasr_top.sv */
/*
 dasr_top: serial control and readout of a dual simultaneous sampling converter.
 assumes: host drives i_cs_n, i_sclk and i_sdi; i_sclk runs only inside frames;
 analog core gives results and alert events as plain inputs.
*/
`include "dasr_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module dasr_top #(
    parameter int RES_BITS = 16
) (
    // clocks and reset
    input wire logic i_mclk,
    input wire logic i_sys_rst,
    input wire logic i_sclk,
    // serial pins from host
    input wire logic i_cs_n,
    input wire logic i_sdi,
    // serial pins to host
    output logic o_serial_out_a,
    output logic o_serial_out_a_oe,
    output logic o_sdob,
    output logic o_sdob_oe,
    // analog core hooks
    input wire dasr_pkg::dasr_sample_t i_result_a,
    input wire dasr_pkg::dasr_sample_t i_result_b,
    input wire logic [3:0] i_alert_event,
    input wire logic i_selftest_fault,
    output logic o_conv_start,
    output logic o_hold,
    output logic o_ref_buffer_en,
    output logic o_power_down,
    output logic o_flush,
    output logic o_osc_reset,
    output logic o_ref_reset,
    output logic o_setup_fail
);
    import dasr_pkg::*;

    initial begin
        if (RES_BITS != 12 && RES_BITS != 14 && RES_BITS != 16) begin
            $error("RES_BITS must be 12, 14 or 16");
        end
    end

    function automatic logic [7:0] crc_step(input logic [7:0] c, input logic b);
        logic fb;
        fb = c[7] ^ b;
        return {c[6:0], 1'b0} ^ (fb ? `DASR_CRC_POLY : 8'h00);
    endfunction

    // left-aligned serial stream: a, optionally b, optionally checksum over a and, when b_crc is set, b
    function automatic logic [43:0] pack(input dasr_sample_t a, input dasr_sample_t b, input logic [4:0] w,
                                         input logic b_crc, input logic b_put, input logic crc_on);
        logic [43:0] s;
        logic [7:0] c;
        int n;
        s = '0;
        c = `DASR_CRC_INIT;
        n = 0;
        for (int i = 17; i >= 0; i--) begin
            if (i < int'(w)) begin
                s[43 - n] = a[i];
                c = crc_step(c, a[i]);
                n++;
            end
        end
        for (int i = 17; i >= 0; i--) begin
            if (i < int'(w) && b_crc) begin
                c = crc_step(c, b[i]);
                if (b_put) begin
                    s[43 - n] = b[i];
                    n++;
                end
            end
        end
        if (crc_on) begin
            for (int i = 7; i >= 0; i--) begin
                s[43 - n] = c[i];
                n++;
            end
        end
        return s;
    endfunction

    // ---------------- link domain ----------------
    logic link_rst;
    logic [5:0] tx_cnt;
    logic [5:0] rx_cnt;
    logic [22:0] rx_sh;
    logic [15:0] cmd_word;
    logic [7:0] crc_byte;
    logic tog16;
    logic tog24;
    logic [43:0] stream_a;
    logic [43:0] stream_b;
    logic alert_pin;
    logic one_lane;
    logic alert_en;

    assign link_rst = i_sys_rst | i_cs_n;

    // output bit counter, shifts on rising clock edges
    always_ff @(posedge i_sclk or posedge link_rst) begin
        if (link_rst) begin
            tx_cnt <= 6'h00;
        end else if (tx_cnt != 6'h3f) begin
            tx_cnt <= tx_cnt + 6'h01;
        end
    end

    // input bit counter on falling edges
    always_ff @(negedge i_sclk or posedge link_rst) begin
        if (link_rst) begin
            rx_cnt <= 6'h00;
        end else if (rx_cnt != 6'h3f) begin
            rx_cnt <= rx_cnt + 6'h01;
        end
    end

    // command capture after the sixteenth and twenty-fourth bit
    always_ff @(negedge i_sclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            rx_sh <= 23'h000000;
            cmd_word <= 16'h0000;
            crc_byte <= 8'h00;
            tog16 <= 1'b0;
            tog24 <= 1'b0;
        end else begin
            rx_sh <= {rx_sh[21:0], i_sdi};
            if (rx_cnt == 6'h0f) begin
                cmd_word <= {rx_sh[14:0], i_sdi};
                tog16 <= ~tog16;
            end
            if (rx_cnt == 6'h17) begin
                crc_byte <= {rx_sh[6:0], i_sdi};
                tog24 <= ~tog24;
            end
        end
    end

    // serial data: only a soft or hard reset changes the stream words during a frame
    always_comb begin
        o_serial_out_a = 1'b0;
        o_sdob = 1'b0;
        if (tx_cnt <= 6'h2b) begin
            o_serial_out_a = stream_a[6'h2b - tx_cnt];
            o_sdob = (one_lane && alert_en) ? alert_pin : stream_b[6'h2b - tx_cnt];
        end
    end

    // ---------------- oscillator domain ----------------
    logic [2:0] cs_s;
    logic [2:0] t16_s;
    logic [2:0] t24_s;
    logic cs_lvl;
    logic t16_lvl;
    logic t24_lvl;
    logic cs_fall;
    logic cs_rise;
    logic ev16;
    logic ev24;

    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            cs_s <= 3'h7;
            t16_s <= 3'h0;
            t24_s <= 3'h0;
            cs_lvl <= 1'b1;
            t16_lvl <= 1'b0;
            t24_lvl <= 1'b0;
            cs_fall <= 1'b0;
            cs_rise <= 1'b0;
            ev16 <= 1'b0;
            ev24 <= 1'b0;
        end else begin
            cs_s <= {cs_s[1:0], i_cs_n};
            t16_s <= {t16_s[1:0], tog16};
            t24_s <= {t24_s[1:0], tog24};
            cs_fall <= 1'b0;
            cs_rise <= 1'b0;
            ev16 <= 1'b0;
            ev24 <= 1'b0;
            if (cs_s[1] == cs_s[2] && cs_s[2] != cs_lvl) begin
                cs_lvl <= cs_s[2];
                cs_fall <= ~cs_s[2];
                cs_rise <= cs_s[2];
            end
            if (t16_s[1] == t16_s[2] && t16_s[2] != t16_lvl) begin
                t16_lvl <= t16_s[2];
                ev16 <= 1'b1;
            end
            if (t24_s[1] == t24_s[2] && t24_s[2] != t24_lvl) begin
                t24_lvl <= t24_s[2];
                ev24 <= 1'b1;
            end
        end
    end

    dasr_word_t pri;
    dasr_word_t sec;
    logic [4:0] alert_st;
    logic [7:0] cmd_crc;
    logic [43:0] cmd_pack;
    logic pend_crc;
    logic exec_go;
    logic wr_go;
    logic rd_go;
    logic [2:0] cmd_addr;
    logic sw_soft;
    logic sw_hard;
    logic sw_any;
    logic crc_w;
    logic boost;
    logic [4:0] width;

    assign crc_w = pri[`DASR_PRI_CRC_W];
    assign one_lane = sec[`DASR_SEC_LANE];
    assign alert_en = sec[`DASR_SEC_ALERT_EN];
    assign boost = pri[`DASR_PRI_RES] && (pri[`DASR_PRI_OSR_MSB:`DASR_PRI_OSR_LSB] != 3'h0);
    assign width = boost ? 5'(RES_BITS + 2) : 5'(RES_BITS);
    assign cmd_addr = cmd_word[`DASR_CMD_ADDR_MSB:`DASR_CMD_ADDR_LSB];
    assign cmd_pack = pack({2'b00, cmd_word}, 18'h00000, 5'd16, 1'b0, 1'b0, 1'b1);
    assign cmd_crc = cmd_pack[27:20];
    assign exec_go = (ev16 && !crc_w) || (ev24 && pend_crc && cmd_crc == crc_byte);
    assign wr_go = exec_go && cmd_word[`DASR_CMD_WRITE];
    assign rd_go = exec_go && !cmd_word[`DASR_CMD_WRITE] && cmd_addr != `DASR_ADDR_NOP;
    assign sw_soft = wr_go && cmd_addr == `DASR_ADDR_SEC &&
                     cmd_word[`DASR_SEC_RST_MSB:`DASR_SEC_RST_LSB] == `DASR_RST_SOFT;
    assign sw_hard = wr_go && cmd_addr == `DASR_ADDR_SEC &&
                     cmd_word[`DASR_SEC_RST_MSB:`DASR_SEC_RST_LSB] == `DASR_RST_HARD;
    assign sw_any = sw_soft | sw_hard;

    // write checksum wait
    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            pend_crc <= 1'b0;
        end else if (cs_rise || sw_any || ev24) begin
            pend_crc <= 1'b0;
        end else if (ev16 && crc_w) begin
            pend_crc <= 1'b1;
        end
    end

    // configuration words
    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            pri <= `DASR_PRI_RESET;
            sec <= `DASR_SEC_RESET;
        end else if (sw_hard) begin
            pri <= `DASR_PRI_RESET;
            sec <= `DASR_SEC_RESET;
        end else if (wr_go && !sw_soft) begin
            if (cmd_addr == `DASR_ADDR_PRI) begin
                pri <= cmd_word[`DASR_CMD_DATA_MSB:0];
            end
            if (cmd_addr == `DASR_ADDR_SEC) begin
                sec <= cmd_word[`DASR_CMD_DATA_MSB:0] & ~12'h300;
            end
        end
    end

    // self test after power-on or hard reset
    dasr_st_e st;
    logic [2:0] st_cnt;
    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            st <= DASR_ST_TEST;
            st_cnt <= 3'h0;
            o_setup_fail <= 1'b0;
        end else if (sw_hard) begin
            st <= DASR_ST_TEST;
            st_cnt <= 3'h0;
            o_setup_fail <= 1'b0;
        end else begin
            case (st)
                DASR_ST_TEST: begin
                    if (st_cnt == 3'(`DASR_SELFTEST_CYC - 1)) begin
                        st <= DASR_ST_RUN;
                        o_setup_fail <= i_selftest_fault || pri != `DASR_PRI_RESET ||
                                        sec != `DASR_SEC_RESET;
                    end else begin
                        st_cnt <= st_cnt + 3'h1;
                    end
                end
                DASR_ST_RUN: begin
                    st <= DASR_ST_RUN;
                end
                default: begin
                    st <= DASR_ST_TEST;
                end
            endcase
        end
    end

    // conversion control
    logic conv_busy;
    logic conv_done;
    dasr_conv_timer #(.CYC(`DASR_CONV_CYC)) u_timer (
        .i_mclk(i_mclk),
        .i_sys_rst(i_sys_rst),
        .i_start(cs_fall),
        .i_abort(sw_any),
        .o_busy(conv_busy),
        .o_done(conv_done)
    );

    // alert status: hardware set wins over a software reset clear
    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            alert_st <= 5'h00;
            alert_pin <= 1'b0;
        end else begin
            alert_st <= (sw_any ? 5'h00 : alert_st) | {o_setup_fail, conv_done ? i_alert_event : 4'h0};
            if (conv_done && i_alert_event != 4'h0) begin
                alert_pin <= 1'b1;
            end else if (cs_fall || sw_any) begin
                alert_pin <= 1'b0;
            end
        end
    end

    // result and register readback staging, copied to the stream words only while select is high
    dasr_sample_t res_a;
    dasr_sample_t res_b;
    logic res_pend;
    logic rd_pend;
    logic rd_hold;
    logic [2:0] rd_addr;
    dasr_word_t rd_data;

    always_comb begin
        case (rd_addr)
            `DASR_ADDR_PRI: rd_data = pri;
            `DASR_ADDR_SEC: rd_data = sec;
            `DASR_ADDR_ALERT: rd_data = {7'h00, alert_st};
            default: rd_data = 12'h000;
        endcase
    end

    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            res_a <= 18'h00000;
            res_b <= 18'h00000;
            res_pend <= 1'b0;
            rd_pend <= 1'b0;
            rd_hold <= 1'b0;
            rd_addr <= 3'h0;
            stream_a <= 44'h0;
            stream_b <= 44'h0;
        end else if (sw_any) begin
            res_pend <= 1'b0;
            rd_pend <= 1'b0;
            rd_hold <= 1'b0;
            stream_a <= 44'h0;
            stream_b <= 44'h0;
        end else begin
            if (conv_done) begin
                res_a <= i_result_a;
                res_b <= i_result_b;
                res_pend <= 1'b1;
            end
            if (rd_go) begin
                rd_pend <= 1'b1;
                rd_addr <= cmd_addr;
            end
            if (cs_rise) begin
                rd_hold <= 1'b0;
            end
            if (cs_lvl && !cs_rise && rd_pend) begin
                stream_a <= pack({3'h0, rd_addr, rd_data}, 18'h00000, 5'd16, 1'b0, 1'b0,
                                 pri[`DASR_PRI_CRC_R]);
                stream_b <= 44'h0;
                rd_pend <= 1'b0;
                rd_hold <= 1'b1;
            end else if (cs_lvl && !cs_rise && res_pend && !rd_hold && !conv_done) begin
                stream_a <= pack(res_a, res_b, width, 1'b1, one_lane, pri[`DASR_PRI_CRC_R]);
                stream_b <= pack(res_b, 18'h00000, width, 1'b0, 1'b0, 1'b0);
                res_pend <= 1'b0;
            end
        end
    end

    // pin enables and status outputs
    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_serial_out_a_oe <= 1'b0;
            o_sdob_oe <= 1'b0;
        end else if (cs_fall) begin
            o_serial_out_a_oe <= 1'b1;
            o_sdob_oe <= !one_lane || alert_en;
        end else if (cs_rise) begin
            o_serial_out_a_oe <= 1'b0;
            o_sdob_oe <= 1'b0;
        end
    end

    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_conv_start <= 1'b0;
            o_hold <= 1'b0;
            o_ref_buffer_en <= 1'b1;
            o_power_down <= 1'b0;
            o_flush <= 1'b0;
            o_osc_reset <= 1'b0;
            o_ref_reset <= 1'b0;
        end else begin
            o_conv_start <= cs_fall;
            o_hold <= cs_fall | conv_busy;
            o_ref_buffer_en <= !pri[`DASR_PRI_REFERENCE_SOURCE_SELECT];
            o_power_down <= pri[`DASR_PRI_PMODE];
            o_flush <= sw_any;
            o_osc_reset <= sw_hard;
            o_ref_reset <= sw_hard;
        end
    end

    // checks
    localparam int A_CONV_MAX = 64;
    sequence s_fall;
        cs_fall;
    endsequence
    sequence s_done_soon;
        ##[1:A_CONV_MAX] conv_done;
    endsequence

    a_conv_timed: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
        s_fall and !sw_any |-> s_done_soon) else $error("conversion did not finish");
    a_hold_start: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
        s_fall |=> o_conv_start && o_hold && o_serial_out_a_oe) else $error("select fall did not start");
    a_release_out: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
        cs_rise && !cs_fall |=> !o_serial_out_a_oe && !o_sdob_oe) else $error("outputs not released");
    a_ref_buffer: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
        ##1 o_ref_buffer_en == !$past(pri[`DASR_PRI_REFERENCE_SOURCE_SELECT])) else $error("reference buffer mismatch");
    a_soft_keep: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
        sw_soft |=> pri == $past(pri) && !res_pend && o_flush) else $error("soft reset lost config");
    a_hard_default: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
        sw_hard |=> pri == `DASR_PRI_RESET && sec == `DASR_SEC_RESET && o_osc_reset) else $error("hard reset");
    a_alert_clear: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
        sw_any && !conv_done && !o_setup_fail |=> alert_st == 5'h00) else $error("alert not cleared");
    a_selftest_flag: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
        sw_hard ##1 (!sw_hard && i_selftest_fault) [*4] |=> o_setup_fail) else $error("self test flag");
    a_crc_guard: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
        wr_go && crc_w |-> ev24 && cmd_crc == crc_byte) else $error("unchecked write taken");
    a_lane_one: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
        s_fall and (one_lane && !alert_en) |=> !o_sdob_oe) else $error("second lane driven");
endmodule
`default_nettype wire

/* logic/dasr_consts.svh */
/*
 dasr_consts.svh: offsets, field positions, reset values and timing counts of the
 dual converter serial readout block.
 assumes: included by bare name from every file that needs the constants.
*/
`ifndef DASR_CONSTS_SVH
`define DASR_CONSTS_SVH

// register addresses carried in command bits 14..12
`define DASR_ADDR_NOP 3'h0
`define DASR_ADDR_PRI 3'h1
`define DASR_ADDR_SEC 3'h2
`define DASR_ADDR_ALERT 3'h3

// command word layout
`define DASR_CMD_WRITE 15
`define DASR_CMD_ADDR_MSB 14
`define DASR_CMD_ADDR_LSB 12
`define DASR_CMD_DATA_MSB 11

// primary_config_word fields
`define DASR_PRI_REFERENCE_SOURCE_SELECT 0
`define DASR_PRI_PMODE 1
`define DASR_PRI_RES 2
`define DASR_PRI_CRC_R 3
`define DASR_PRI_CRC_W 4
`define DASR_PRI_OSR_LSB 5
`define DASR_PRI_OSR_MSB 7
`define DASR_PRI_RESET 12'h000

// secondary_config_word fields
`define DASR_SEC_LANE 0
`define DASR_SEC_ALERT_EN 1
`define DASR_SEC_RST_LSB 8
`define DASR_SEC_RST_MSB 9
`define DASR_SEC_RESET 12'h000
`define DASR_RST_SOFT 2'h1
`define DASR_RST_HARD 2'h2

// checksum
`define DASR_CRC_POLY 8'h07
`define DASR_CRC_INIT 8'hff

// timing
`define DASR_MCLK_NS 40
`define DASR_CONV_NS 200
`define DASR_CONV_CYC ((`DASR_CONV_NS + `DASR_MCLK_NS - 1) / `DASR_MCLK_NS)
`define DASR_SELFTEST_CYC 4
`define DASR_FRAME_BITS 44

`endif

/* logic/dasr_pkg.sv */
/*
 dasr_pkg: types of the dual converter serial readout block.
 assumes: compiled before every module of the block.
*/
package dasr_pkg;
    typedef logic [11:0] dasr_word_t;
    typedef logic [17:0] dasr_sample_t;
    typedef enum logic {DASR_ST_TEST, DASR_ST_RUN} dasr_st_e;
    typedef enum logic {DASR_CV_IDLE, DASR_CV_BUSY} dasr_cv_e;
endpackage

/* logic/dasr_conv_timer.sv */
/*
 dasr_conv_timer: conversion timer on the internal oscillator clock.
 assumes: i_start is a one-cycle pulse in the same clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
module dasr_conv_timer #(
    parameter int CYC = 5
) (
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_sys_rst,
    // control
    input wire logic i_start,
    input wire logic i_abort,
    // status
    output logic o_busy,
    output logic o_done
);
    import dasr_pkg::*;

    initial begin
        if (CYC < 1 || CYC > 255) begin
            $error("conversion cycle count out of range");
        end
    end

    dasr_cv_e state;
    logic [7:0] cnt;

    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            state <= DASR_CV_IDLE;
            cnt <= 8'h00;
            o_done <= 1'b0;
        end else begin
            o_done <= 1'b0;
            case (state)
                DASR_CV_IDLE: begin
                    if (i_start && !i_abort) begin
                        state <= DASR_CV_BUSY;
                        cnt <= 8'h00;
                    end
                end
                DASR_CV_BUSY: begin
                    if (i_abort) begin
                        state <= DASR_CV_IDLE;
                    end else if (cnt == 8'(CYC - 1)) begin
                        state <= DASR_CV_IDLE;
                        o_done <= 1'b1;
                    end else begin
                        cnt <= cnt + 8'h01;
                    end
                end
                default: begin
                    state <= DASR_CV_IDLE;
                end
            endcase
        end
    end

    assign o_busy = (state == DASR_CV_BUSY);
endmodule
`default_nettype wire

/* verif/dasr_host_model.sv */
/*
 dasr_host_model: host serial controller that runs chip-select frames.
 assumes: i_mclk free running; frames are started by the bench.
*/
`timescale 1ns/1ps
`default_nettype none
module dasr_host_model (
    // clock
    input wire logic i_mclk,
    // device outputs
    input wire logic i_serial_out_a,
    input wire logic i_serial_out_a_oe,
    input wire logic i_sdob,
    input wire logic i_sdob_oe,
    // to device
    output logic o_cs_n,
    output logic o_sclk,
    output logic o_sdi
);
    // a released lane reads as the inverse of the level the device output has now
    wire logic pa = i_serial_out_a_oe ? i_serial_out_a : ~i_serial_out_a;
    wire logic pb = i_sdob_oe ? i_sdob : ~i_sdob;
    initial begin
        o_cs_n = 1'b1;
        o_sclk = 1'b0;
        o_sdi = 1'b0;
    end
    task automatic frame(input int n, input logic [43:0] tx, output logic [43:0] qa, output logic [43:0] qb);
        qa = '0;
        qb = '0;
        #3;
        o_cs_n = 1'b0;
        repeat (8) @(posedge i_mclk);
        #3;
        for (int i = 0; i < n; i++) begin
            o_sdi = tx[43 - i];
            #1;
            qa[43 - i] = pa;
            qb[43 - i] = pb;
            o_sclk = 1'b1;
            #3;
            o_sclk = 1'b0;
            #2;
        end
        repeat (8) @(posedge i_mclk);
        #3;
        o_cs_n = 1'b1;
        repeat (10) @(posedge i_mclk);
    endtask
endmodule
`default_nettype wire

/* verif/tb_dual_adc_serial_readout_ctrl.sv */
/*
 tb_dual_adc_serial_readout_ctrl: self-checking bench of the readout block.
 assumes: dasr_pkg compiled first; host model drives the serial pins.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_dual_adc_serial_readout_ctrl;
    import dasr_pkg::*;
    logic i_mclk = 1'b0;
    logic i_sys_rst = 1'b1;
    dasr_sample_t ra = '0;
    dasr_sample_t rb = '0;
    logic [3:0] alert = 4'h0;
    logic fault = 1'b0;
    logic cs_n, sclk, sdi, serial_out_a, serial_out_a_oe, sdob, sdob_oe;
    logic conv_start, ref_en, pd, flush, osc_rst, ref_rst, setup_fail;
    int mismatches = 0;
    int comparisons = 0;
    int cyc = 0;
    int n_conv = 0;
    int n_flush = 0;
    int n_osc = 0;
    logic [31:0] seed = 32'h42;
    logic [43:0] qa, qb, d;
    always #20 i_mclk = ~i_mclk;
    dasr_host_model u_host (.i_mclk(i_mclk), .i_serial_out_a(serial_out_a), .i_serial_out_a_oe(serial_out_a_oe), .i_sdob(sdob),
        .i_sdob_oe(sdob_oe), .o_cs_n(cs_n), .o_sclk(sclk), .o_sdi(sdi));
    dasr_top #(.RES_BITS(16)) u_dut (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_sclk(sclk), .i_cs_n(cs_n),
        .i_sdi(sdi), .o_serial_out_a(serial_out_a), .o_serial_out_a_oe(serial_out_a_oe), .o_sdob(sdob), .o_sdob_oe(sdob_oe),
        .i_result_a(ra), .i_result_b(rb), .i_alert_event(alert), .i_selftest_fault(fault),
        .o_conv_start(conv_start), .o_hold(), .o_ref_buffer_en(ref_en), .o_power_down(pd),
        .o_flush(flush), .o_osc_reset(osc_rst), .o_ref_reset(ref_rst), .o_setup_fail(setup_fail));
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    function automatic logic [43:0] cmd(input logic w, input logic [2:0] a, input logic [11:0] v);
        return {w, a, v, 28'h0};
    endfunction
    // checksum x^8+x^2+x+1, first eight bits inverted, msb first
    function automatic logic [7:0] crc8(input logic [15:0] v);
        logic [7:0] c;
        c = 8'hff;
        for (int i = 15; i >= 0; i--) begin
            c = {c[6:0], 1'b0} ^ ((c[7] ^ v[i]) ? 8'h07 : 8'h00);
        end
        return c;
    endfunction
    task end_of_test;
        if (mismatches == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task chk(input string nm, input logic [43:0] e, input logic [43:0] g);
        comparisons++;
        if (g !== e) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    task rd(input logic [2:0] a, output logic [43:0] q);
        u_host.frame(16, cmd(1'b0, a, 12'h0), q, qb);
        u_host.frame(16, 44'h0, q, qb);
    endtask
    task conv(input int n);
        @(posedge i_mclk);
        seed = xs(seed);
        ra <= {2'h0, seed[31:16]};
        rb <= {2'h0, seed[15:0]};
        u_host.frame(16, 44'h0, qa, qb);
        u_host.frame(n, 44'h0, qa, qb);
    endtask
    always @(posedge i_mclk) begin
        cyc++;
        n_conv += (conv_start === 1'b1);
        n_flush += (flush === 1'b1);
        n_osc += (osc_rst === 1'b1) + (ref_rst === 1'b1);
        if (cyc == 5000) begin
            mismatches++;
            end_of_test();
        end
    end
    initial begin
        repeat (8) @(posedge i_mclk);
        i_sys_rst <= 1'b0;
        repeat (10) @(posedge i_mclk);
        chk("setup_fail", 44'h0, setup_fail);
        chk("ref_buffer_en", 44'h1, ref_en);
        for (int k = 0; k < 3; k++) begin
            conv(16);
            chk("lane_a", {ra[15:0], 28'h0}, qa);
            chk("lane_b", {rb[15:0], 28'h0}, qb);
            chk("oe_release", 44'h0, {serial_out_a_oe, sdob_oe});
        end
        chk("conv_starts", 44'h6, n_conv);
        u_host.frame(16, cmd(1'b1, 3'h1, 12'h003), qa, qb);
        chk("ref_buffer_en", 44'h0, ref_en);
        chk("power_down", 44'h1, pd);
        @(posedge i_mclk);
        alert <= 4'h5;
        u_host.frame(16, 44'h0, qa, qb);
        alert <= 4'h0;
        u_host.frame(16, cmd(1'b1, 3'h2, 12'h100), qa, qb);
        chk("flush", 44'h1, n_flush);
        rd(3'h3, d);
        chk("alert_reg", {4'h3, 12'h000, 28'h0}, d);
        rd(3'h1, d);
        chk("primary_reg", {4'h1, 12'h003, 28'h0}, d);
        u_host.frame(16, cmd(1'b1, 3'h2, 12'h001), qa, qb);
        conv(32);
        chk("one_lane", {ra[15:0], rb[15:0], 12'h0}, qa);
        u_host.frame(16, cmd(1'b1, 3'h1, 12'h013), qa, qb);
        u_host.frame(16, cmd(1'b1, 3'h1, 12'h000), qa, qb);
        chk("crc_w_ignore", 44'h1, pd);
        u_host.frame(24, {1'b1, 3'h1, 12'h009, crc8({1'b1, 3'h1, 12'h009}), 20'h0}, qa, qb);
        chk("crc_w_accept", 44'h0, pd);
        u_host.frame(16, cmd(1'b0, 3'h2, 12'h0), qa, qb);
        u_host.frame(24, 44'h0, d, qb);
        chk("crc_r_reg", {16'h2001, crc8(16'h2001), 20'h0}, d);
        @(posedge i_mclk);
        fault <= 1'b1;
        u_host.frame(16, cmd(1'b1, 3'h2, 12'h200), qa, qb);
        repeat (10) @(posedge i_mclk);
        chk("ref_buffer_en", 44'h1, ref_en);
        chk("osc_ref_reset", 44'h2, n_osc);
        chk("setup_fail", 44'h1, setup_fail);
        end_of_test();
    end
endmodule
`default_nettype wire
